/* core/grt_defines.vh */
// Constants for the graphics raster timing and pattern write block.
`ifndef GRT_DEFINES_VH
`define GRT_DEFINES_VH

`define GRT_DIV_LOAD     4'h7
`define GRT_DIV_TRAIN_B  4'h8
`define GRT_DIV_LAST     4'h9

`define GRT_WORD_LAST    5'h1F
`define GRT_WORD_RETRACE 5'h15
`define GRT_LINES        9'h186
`define GRT_LINE_MAX     9'h1FF

`define GRT_PHASE_LAST   4'hF
`define GRT_PHASE_MID    4'h7
`define GRT_PHASE_SOF    4'hE
`define GRT_SUB_ROW_ON   3'h1
`define GRT_SUB_MUX_ON   3'h2
`define GRT_SUB_COL_ON   3'h3
`define GRT_SUB_STB_OFF  3'h6
`define GRT_SUB_LOAD     3'h7

`define GRT_SOF_TERMINAL 5'h1E

`define GRT_MODE_CLEAR   2'h0
`define GRT_MODE_SET     2'h1
`define GRT_MODE_INVERT  2'h2
`define GRT_MODE_PATTERN 2'h3

`define GRT_SCALE_CARRY  4'hF

`define GRT_WS_IDLE      3'h0
`define GRT_WS_RD_WAIT   3'h1
`define GRT_WS_READ      3'h2
`define GRT_WS_WR_WAIT   3'h3
`define GRT_WS_WRITE     3'h4

`endif

/* core/grt_pattern.v */
// Scaled recirculating pattern and drawing mode data selection.
`timescale 1ns/1ns
`include "grt_defines.vh"

module grt_pattern (
  // Clock and reset
  input  wire       clk,
  input  wire       rst,
  // Pattern setup
  input  wire       pattern_write,
  input  wire [7:0] pattern_byte,
  input  wire [3:0] scale_value,
  // Per write
  input  wire       step,
  input  wire [1:0] mode,
  input  wire       old_bit,
  output reg        wr_bit,
  output reg        wr_enable
);

  reg  [7:0] pat_q;
  reg  [3:0] scale_cnt_q;
  reg  [3:0] scale_pre_q;
  wire       pat_bit;

  assign pat_bit = pat_q[0];

  always @(posedge clk) begin
    if (rst) begin
      pat_q       <= 8'hFF;
      scale_cnt_q <= `GRT_SCALE_CARRY;
      scale_pre_q <= `GRT_SCALE_CARRY;
    end else if (pattern_write) begin
      pat_q       <= pattern_byte;
      scale_pre_q <= ~(scale_value - 4'h1);
      scale_cnt_q <= ~(scale_value - 4'h1);
    end else if (step) begin
      if (scale_cnt_q == `GRT_SCALE_CARRY) begin
        pat_q       <= {pat_q[0], pat_q[7:1]};
        scale_cnt_q <= scale_pre_q;
      end else begin
        scale_cnt_q <= scale_cnt_q + 4'h1;
      end
    end
  end

  always @* begin
    wr_enable = pat_bit;
    case (mode)
      `GRT_MODE_CLEAR:   wr_bit = 1'b0;
      `GRT_MODE_SET:     wr_bit = 1'b1;
      `GRT_MODE_INVERT:  wr_bit = ~old_bit;
      `GRT_MODE_PATTERN: begin
        wr_bit    = pat_bit;
        wr_enable = 1'b1;
      end
      default:           wr_bit = 1'b0;
    endcase
  end

endmodule

/* core/grt_raster.v */
// Graphics raster timing, display fetch, video shift and dot write sequencing.
`timescale 1ns/1ns
`include "grt_defines.vh"

module grt_raster #(
  parameter [8:0] NUM_LINES = `GRT_LINES
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // Alphanumeric timing
  input  wire        char_load_strobe,
  input  wire        character_rate_clock,
  // Vector controller
  input  wire        dot_req,
  input  wire [8:0]  dot_x,
  input  wire [8:0]  dot_y,
  input  wire        draw_select_lo,
  input  wire        draw_select_hi,
  input  wire        pattern_write,
  input  wire [7:0]  pattern_byte,
  input  wire [3:0]  scale_value,
  output reg         dot_req_clear,
  // Display memory
  input  wire [15:0] mem_rdata,
  output reg  [13:0] mem_addr,
  output reg         graphics_row_strobe,
  output reg         row_column_select,
  output reg         graphics_column_strobe,
  output reg  [15:0] mem_bit_we,
  output reg  [15:0] mem_wdata,
  // Video
  output reg         graphics_dot_clock,
  output reg         display_cycle_phase,
  output reg         video_shift_load,
  output reg         graphics_horizontal_blank,
  output reg         serial_video,
  output reg         frame_start
);

  // Dot rate divider.
  reg  [3:0]  div_q;
  reg         div_run_q;
  wire        gdot_en;

  // The divider idles until the first character load strobe, so the graphics
  // dots keep a fixed phase to the character cells; later strobes are ignored.
  always @(posedge clk) begin
    if (rst) begin
      div_q     <= 4'h0;
      div_run_q <= 1'b0;
    end else if (char_load_strobe && !div_run_q) begin
      div_q     <= `GRT_DIV_LOAD;
      div_run_q <= 1'b1;
    end else if (div_run_q) begin
      div_q     <= (div_q == `GRT_DIV_LAST) ? `GRT_DIV_LOAD : div_q + 4'h1;
    end
  end

  // Train A fires on the preset state, train B one alpha dot later; the OR
  // gives two graphics dots every three alpha dots.
  assign gdot_en = div_run_q && ((div_q == `GRT_DIV_LOAD) ||
                                 (div_q == `GRT_DIV_TRAIN_B));

  // Raster counters.
  reg  [3:0]  phase_q;
  reg  [4:0]  word_q;
  reg  [8:0]  line_q;
  reg         retrace_q;
  reg         running_q;
  reg         skip_q;
  reg  [1:0]  stall_q;
  wire        stalled;
  wire        tick;
  wire        vert;
  wire        disp_off;

  assign stalled  = |stall_q;
  assign tick     = running_q && gdot_en && !stalled && !frame_start;
  assign vert     = (line_q >= NUM_LINES);
  assign disp_off = !running_q || retrace_q || vert;

  // The stall register freezes the phase counter for two dot ticks after each
  // line, which keeps the raster locked to the sweep at the cost of two dots.
  always @(posedge clk) begin
    if (rst) begin
      phase_q   <= 4'h0;
      word_q    <= 5'h00;
      line_q    <= 9'h000;
      retrace_q <= 1'b0;
      running_q <= 1'b0;
      skip_q    <= 1'b0;
      stall_q   <= 2'h0;
    end else if (frame_start) begin
      // Preset so the first word is fetched and loaded ten dots after start.
      phase_q   <= `GRT_PHASE_SOF;
      word_q    <= 5'h00;
      line_q    <= 9'h000;
      retrace_q <= 1'b0;
      running_q <= 1'b1;
      skip_q    <= 1'b1;
      stall_q   <= 2'h0;
    end else if (running_q && gdot_en && stalled) begin
      stall_q   <= {1'b0, stall_q[1]};
    end else if (tick) begin
      phase_q <= phase_q + 4'h1;
      if (phase_q == `GRT_PHASE_LAST) begin
        if (skip_q) begin
          skip_q <= 1'b0;
        end else if (word_q != `GRT_WORD_LAST) begin
          word_q <= word_q + 5'h01;
        end else if (!retrace_q) begin
          retrace_q <= 1'b1;
          word_q    <= `GRT_WORD_RETRACE;
        end else begin
          retrace_q <= 1'b0;
          word_q    <= 5'h00;
          stall_q   <= 2'h3;
          if (line_q != `GRT_LINE_MAX) begin
            line_q <= line_q + 9'h001;
          end
        end
      end
    end
  end

  // Frame start counts character clocks once the last line has gone.
  // The line counter saturates while the frame waits, so the screen stays
  // blank until frame start whatever the line count.
  reg  [4:0]  sof_cnt_q;
  reg         frame_start_count;

  always @(posedge clk) begin
    if (rst) begin
      sof_cnt_q         <= 5'h00;
      frame_start_count <= 1'b0;
      frame_start       <= 1'b0;
    end else if (character_rate_clock) begin
      frame_start <= frame_start_count;
      if (frame_start) begin
        sof_cnt_q         <= 5'h00;
        frame_start_count <= 1'b0;
        frame_start       <= 1'b0;
      end else if ((!running_q || vert) && !frame_start_count) begin
        sof_cnt_q <= sof_cnt_q + 5'h01;
        if (sof_cnt_q + 5'h01 == `GRT_SOF_TERMINAL) begin
          frame_start_count <= 1'b1;
        end
      end
    end
  end

  // Dot write sequencer.
  // A request is taken only at the end of a write half, so its read falls in
  // the next high half and its write in the one after. The pattern steps once
  // per write, whether the write is masked or not.
  reg  [2:0]  ws_q;
  reg  [15:0] rd_word_q;
  wire        end_low;
  wire        end_high;
  wire        wr_bit;
  wire        wr_enable;
  wire        ws_mem;
  wire        step;
  wire [15:0] bit_sel;

  assign end_low  = tick && (phase_q == `GRT_PHASE_MID);
  assign end_high = tick && (phase_q == `GRT_PHASE_LAST);
  assign ws_mem   = (ws_q == `GRT_WS_READ) || (ws_q == `GRT_WS_WRITE);
  assign step     = end_high && (ws_q == `GRT_WS_WRITE);
  assign bit_sel  = 16'h0001 << dot_x[3:0];

  always @(posedge clk) begin
    if (rst) begin
      ws_q      <= `GRT_WS_IDLE;
      rd_word_q <= 16'h0000;
    end else begin
      case (ws_q)
        `GRT_WS_IDLE: begin
          if (end_high && dot_req) begin
            ws_q <= `GRT_WS_RD_WAIT;
          end
        end
        `GRT_WS_RD_WAIT: begin
          if (end_low) begin
            ws_q <= `GRT_WS_READ;
          end
        end
        `GRT_WS_READ: begin
          if (end_high) begin
            // The word is kept for invert mode; the other modes ignore it.
            rd_word_q <= mem_rdata;
            ws_q      <= `GRT_WS_WR_WAIT;
          end
        end
        `GRT_WS_WR_WAIT: begin
          if (end_low) begin
            ws_q <= `GRT_WS_WRITE;
          end
        end
        `GRT_WS_WRITE: begin
          if (end_high) begin
            ws_q <= `GRT_WS_IDLE;
          end
        end
        default: ws_q <= `GRT_WS_IDLE;
      endcase
    end
  end

  grt_pattern i_grt_pattern (
    .clk           (clk),
    .rst           (rst),
    .pattern_write (pattern_write),
    .pattern_byte  (pattern_byte),
    .scale_value   (scale_value),
    .step          (step),
    .mode          ({draw_select_hi, draw_select_lo}),
    .old_bit       (|(rd_word_q & bit_sel)),
    .wr_bit        (wr_bit),
    .wr_enable     (wr_enable)
  );

  // Strobe generation from the low phase bits.
  wire [2:0]  sub;
  wire        low_half;
  wire        slot_on;

  // Sub-phase window shared by the three strobes and the write lane.
  function in_window;
    input [2:0] sub_phase;
    input [2:0] lo_sub;
    begin
      in_window = (sub_phase >= lo_sub) && (sub_phase <= `GRT_SUB_STB_OFF);
    end
  endfunction

  assign sub      = phase_q[2:0];
  assign low_half = !phase_q[3];
  // Display slot runs in the low half, write slot in the high half.
  assign slot_on  = running_q && !stalled &&
                    (low_half ? !disp_off : ws_mem);

  always @(posedge clk) begin
    if (rst) begin
      graphics_row_strobe    <= 1'b0;
      row_column_select      <= 1'b0;
      graphics_column_strobe <= 1'b0;
      mem_addr               <= 14'h0000;
      mem_bit_we             <= 16'h0000;
      mem_wdata              <= 16'h0000;
      dot_req_clear          <= 1'b0;
      display_cycle_phase    <= 1'b0;
      graphics_dot_clock     <= 1'b0;
    end else begin
      graphics_row_strobe    <= slot_on && in_window(sub, `GRT_SUB_ROW_ON);
      row_column_select      <= slot_on && in_window(sub, `GRT_SUB_MUX_ON);
      graphics_column_strobe <= slot_on && in_window(sub, `GRT_SUB_COL_ON);
      // Display address is line and word; dot address is Y and the X word.
      mem_addr <= low_half ? {line_q, word_q} : {dot_y, dot_x[8:4]};
      // Only the addressed lane is enabled, so the other fifteen dots of the
      // word are never rewritten, even in invert mode.
      if ((ws_q == `GRT_WS_WRITE) && wr_enable && !stalled &&
          in_window(sub, `GRT_SUB_COL_ON)) begin
        mem_bit_we <= bit_sel;
      end else begin
        mem_bit_we <= 16'h0000;
      end
      mem_wdata           <= {16{wr_bit}};
      dot_req_clear       <= step;
      display_cycle_phase <= phase_q[3];
      graphics_dot_clock  <= gdot_en;
    end
  end

  // Video shift register; blank forbids loading so retrace shifts zeros.
  reg  [15:0] shift_q;
  wire        load_now;

  assign load_now = tick && low_half && (sub == `GRT_SUB_LOAD) && !disp_off;

  always @(posedge clk) begin
    if (rst) begin
      shift_q                   <= 16'h0000;
      serial_video              <= 1'b0;
      video_shift_load          <= 1'b0;
      graphics_horizontal_blank <= 1'b1;
    end else begin
      video_shift_load          <= load_now;
      graphics_horizontal_blank <= disp_off;
      // Every dot tick sends one bit, the load tick too: it sends the last bit
      // of the old word, so all sixteen bits of each word reach the screen.
      if (running_q && gdot_en && !stalled) begin
        serial_video <= shift_q[15];
        if (load_now) begin
          shift_q <= mem_rdata;
        end else begin
          shift_q <= {shift_q[14:0], 1'b0};
        end
      end
    end
  end

endmodule

/* tb/grt_raster_assertions.sv */
// Port-level checks for the graphics raster block.
`timescale 1ns/1ns
module grt_raster_assertions (
  // Clock and reset
  input wire        clk,
  input wire        rst,
  // Observed ports
  input wire        character_rate_clock,
  input wire        dot_req,
  input wire [8:0]  dot_x,
  input wire        dot_req_clear,
  input wire        graphics_row_strobe,
  input wire        row_column_select,
  input wire        graphics_column_strobe,
  input wire [15:0] mem_bit_we,
  input wire [15:0] mem_wdata,
  input wire        graphics_dot_clock,
  input wire        display_cycle_phase,
  input wire        video_shift_load,
  input wire        graphics_horizontal_blank,
  input wire        frame_start
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_dot_clk;
    $fell(graphics_dot_clock) |=> graphics_dot_clock ##1 graphics_dot_clock ##1 !graphics_dot_clock;
  endproperty
  a_dot_clk: assert property (p_dot_clk) else $error("dot clock duty wrong");
  property p_strobe_order;
    (row_column_select |-> graphics_row_strobe) and
    (graphics_column_strobe |-> row_column_select);
  endproperty
  a_strobe_order: assert property (p_strobe_order) else $error("strobe order wrong");
  property p_write_half;
    (mem_bit_we != 16'h0000) |-> display_cycle_phase;
  endproperty
  a_write_half: assert property (p_write_half) else $error("write outside high half");
  property p_write_lane;
    (mem_bit_we != 16'h0000) |-> $onehot(mem_bit_we) && mem_bit_we[dot_x[3:0]] &&
      (mem_wdata == 16'h0000 || mem_wdata == 16'hFFFF);
  endproperty
  a_write_lane: assert property (p_write_lane) else $error("write lane wrong");
  property p_retrace_quiet;
    graphics_horizontal_blank && !display_cycle_phase |-> !graphics_row_strobe;
  endproperty
  a_retrace_quiet: assert property (p_retrace_quiet) else $error("display strobe in blank");
  property p_no_load_blank;
    video_shift_load |-> !graphics_horizontal_blank;
  endproperty
  a_no_load_blank: assert property (p_no_load_blank) else $error("load while blanked");
  property p_frame_edges;
    $changed(frame_start) |-> $past(character_rate_clock);
  endproperty
  a_frame_edges: assert property (p_frame_edges) else $error("frame start off char clock");
  property p_clear_pulse;
    dot_req_clear |-> $past(dot_req) ##1 !dot_req_clear;
  endproperty
  a_clear_pulse: assert property (p_clear_pulse) else $error("dot clear wrong");
  property p_rst_blank;
    disable iff (1'b0) rst |=> graphics_horizontal_blank && !frame_start;
  endproperty
  a_rst_blank: assert property (p_rst_blank) else $error("reset state wrong");
  c_frame: cover property ($rose(frame_start));
  c_clear: cover property (dot_req_clear);
  c_write: cover property (mem_bit_we != 16'h0000);
endmodule
bind grt_raster grt_raster_assertions i_grt_raster_assertions (
  .clk(clk), .rst(rst), .character_rate_clock(character_rate_clock), .dot_req(dot_req),
  .dot_x(dot_x), .dot_req_clear(dot_req_clear), .graphics_row_strobe(graphics_row_strobe),
  .row_column_select(row_column_select), .graphics_column_strobe(graphics_column_strobe),
  .mem_bit_we(mem_bit_we), .mem_wdata(mem_wdata), .graphics_dot_clock(graphics_dot_clock),
  .display_cycle_phase(display_cycle_phase), .video_shift_load(video_shift_load),
  .graphics_horizontal_blank(graphics_horizontal_blank), .frame_start(frame_start));

/* tb/grt_mem_model.sv */
// Word-wide display memory model with per-bit write lanes.
`timescale 1ns/1ns
module grt_mem_model (
  // Clock
  input  wire        clk,
  // Memory port
  input  wire [13:0] mem_addr,
  input  wire        graphics_column_strobe,
  input  wire [15:0] mem_bit_we,
  input  wire [15:0] mem_wdata,
  output wire [15:0] mem_rdata
);
  reg [15:0] mem [0:16383];
  integer    i;
  initial begin
    for (i = 0; i < 16384; i = i + 1) begin
      mem[i] = 16'hA5C3 ^ i[15:0];
    end
  end
  // Only the enabled lane changes, so a stray lane shows up as corrupted neighbours.
  always @(posedge clk) begin
    if (graphics_column_strobe && (mem_bit_we != 16'h0000)) begin
      mem[mem_addr] <= (mem[mem_addr] & ~mem_bit_we) | (mem_wdata & mem_bit_we);
    end
  end
  assign mem_rdata = mem[mem_addr];
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the graphics raster block.
`timescale 1ns/1ns
module tb_top;
  // Stimulus
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg         char_load_strobe = 1'b0;
  reg         character_rate_clock = 1'b0;
  reg         dot_req = 1'b0;
  reg  [8:0]  dot_x = 9'h000;
  reg  [8:0]  dot_y = 9'h000;
  reg         draw_select_lo = 1'b0;
  reg         draw_select_hi = 1'b0;
  reg         pattern_write = 1'b0;
  reg  [7:0]  pattern_byte = 8'h00;
  reg  [3:0]  scale_value = 4'h1;
  // Observed
  wire        dot_req_clear, graphics_row_strobe, row_column_select, graphics_column_strobe;
  wire        graphics_dot_clock, display_cycle_phase, video_shift_load, serial_video;
  wire        graphics_horizontal_blank, frame_start;
  wire [15:0] mem_rdata, mem_bit_we, mem_wdata;
  wire [13:0] mem_addr;
  // Bench state
  integer     bad_count = 0;
  integer     n_compared = 0;
  integer     n_char = 0;
  integer     char_div = 0;
  reg         char_en = 1'b0;
  reg  [7:0]  pat_m;
  reg  [3:0]  scale_m, cnt_m;
  always #2 clk = ~clk;
  always @(posedge clk) begin
    char_div <= (char_div == 11) ? 0 : char_div + 1;
    character_rate_clock <= char_en && (char_div == 11);
    if (char_en && (char_div == 11)) n_char <= n_char + 1;
  end
  grt_raster i_grt_raster (.clk(clk), .rst(rst), .char_load_strobe(char_load_strobe),
    .character_rate_clock(character_rate_clock), .dot_req(dot_req), .dot_x(dot_x),
    .dot_y(dot_y), .draw_select_lo(draw_select_lo), .draw_select_hi(draw_select_hi),
    .pattern_write(pattern_write), .pattern_byte(pattern_byte), .scale_value(scale_value),
    .dot_req_clear(dot_req_clear), .mem_rdata(mem_rdata), .mem_addr(mem_addr),
    .graphics_row_strobe(graphics_row_strobe), .row_column_select(row_column_select),
    .graphics_column_strobe(graphics_column_strobe), .mem_bit_we(mem_bit_we),
    .mem_wdata(mem_wdata), .graphics_dot_clock(graphics_dot_clock),
    .display_cycle_phase(display_cycle_phase), .video_shift_load(video_shift_load),
    .graphics_horizontal_blank(graphics_horizontal_blank), .serial_video(serial_video),
    .frame_start(frame_start));
  grt_mem_model i_grt_mem_model (.clk(clk), .mem_addr(mem_addr),
    .graphics_column_strobe(graphics_column_strobe), .mem_bit_we(mem_bit_we),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  task close_out;
    begin
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task expect_eq(input [15:0] got, input [15:0] exp, input [8*20-1:0] what);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("[ERR] %0t %0s got %h exp %h", $time, what, got, exp);
      end
    end
  endtask
  task wait_blank(input lvl);
    integer n;
    begin
      n = 0;
      while (graphics_horizontal_blank !== lvl && n < 3000) begin
        @(negedge clk);
        n = n + 1;
      end
    end
  endtask
  // Frame start timing and the first fetch after it.
  task t_frame;
    integer    n, b;
    reg [31:0] w;
    begin
      char_en <= 1'b1;
      n = 0;
      while (frame_start !== 1'b1 && n < 2000) begin
        @(negedge clk);
        n = n + 1;
      end
      expect_eq(n_char, 16'd31, "frame start count");
      n = 0;
      while (frame_start !== 1'b0 && n < 100) begin
        @(negedge clk);
        n = n + 1;
      end
      expect_eq(n, 16'd12, "frame start width");
      n = 0;
      while (video_shift_load !== 1'b1 && n < 100) begin
        @(negedge clk);
        n = n + 1;
      end
      expect_eq(n >= 13 && n <= 18, 16'd1, "first load delay");
      w = 32'h00000000;
      b = 0;
      n = 0;
      while (b < 32 && n < 200) begin
        @(negedge clk);
        n = n + 1;
        if (graphics_dot_clock === 1'b1) begin
          w = {w[30:0], serial_video};
          b = b + 1;
        end
      end
      expect_eq(w[31:16], 16'hA5C3, "first video word");
      expect_eq(w[15:0], 16'hA5C2, "second video word");
    end
  endtask
  // One full line: period, loads per line and dot clock rate.
  task t_line;
    integer n, loads, k;
    begin
      wait_blank(1'b0);
      wait_blank(1'b1);
      n = 0;
      loads = 0;
      k = 0;
      while ((graphics_horizontal_blank !== 1'b0 || n == 0) && n < 3000) begin
        @(negedge clk);
        n = n + 1;
        k = k + graphics_dot_clock;
      end
      while (graphics_horizontal_blank !== 1'b1 && n < 3000) begin
        @(negedge clk);
        n = n + 1;
        k = k + graphics_dot_clock;
        loads = loads + video_shift_load;
      end
      expect_eq(n, 16'd1035, "line period");
      expect_eq(loads, 16'd32, "loads per line");
      expect_eq(k, 16'd690, "dot clock count");
    end
  endtask
  task pattern_load(input [7:0] b, input [3:0] s);
    begin
      @(posedge clk);
      pattern_byte <= b;
      scale_value <= s;
      pattern_write <= 1'b1;
      @(posedge clk);
      pattern_write <= 1'b0;
      pat_m = b;
      scale_m = s;
      cnt_m = ~(s - 4'h1);
    end
  endtask
  task dot_write(input [8:0] x, input [8:0] y, input [1:0] m);
    reg [15:0] exp;
    reg        p, nb;
    integer    n;
    begin
      exp = i_grt_mem_model.mem[{y, x[8:4]}];
      p = pat_m[0];
      case (m)
        2'h0: nb = 1'b0;
        2'h1: nb = 1'b1;
        2'h2: nb = ~exp[x[3:0]];
        default: nb = p;
      endcase
      if (m == 2'h3 || p) exp[x[3:0]] = nb;
      if (cnt_m == 4'hF) begin
        pat_m = {pat_m[0], pat_m[7:1]};
        cnt_m = ~(scale_m - 4'h1);
      end else begin
        cnt_m = cnt_m + 4'h1;
      end
      @(posedge clk);
      dot_x <= x;
      dot_y <= y;
      {draw_select_hi, draw_select_lo} <= m;
      dot_req <= 1'b1;
      n = 0;
      while (dot_req_clear !== 1'b1 && n < 300) begin
        @(negedge clk);
        n = n + 1;
      end
      @(posedge clk);
      dot_req <= 1'b0;
      expect_eq(n < 300, 16'd1, "dot clear seen");
      expect_eq(i_grt_mem_model.mem[{y, x[8:4]}], exp, "written word");
    end
  endtask
  // Pattern load then a run of writes cycling through every mode.
  task t_draw(input [7:0] b, input [3:0] s, input integer cnt);
    integer i;
    begin
      pattern_load(b, s);
      for (i = 0; i < cnt; i = i + 1) begin
        dot_write(i * 23 + s, i + s * 3, i % 4);
      end
    end
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    expect_eq({graphics_horizontal_blank, frame_start}, 16'd2, "reset state");
    @(posedge clk);
    char_load_strobe <= 1'b1;
    @(posedge clk);
    char_load_strobe <= 1'b0;
    t_frame;
    t_line;
    t_draw(8'hB4, 4'h2, 12);
    t_draw(8'h01, 4'h1, 10);
    t_draw(8'h6C, 4'h3, 8);
    close_out;
  end
  // A hang costs a mismatch rather than a silent stall.
  initial begin
    #80000;
    bad_count = bad_count + 1;
    $display("[ERR] %0t watchdog expired", $time);
    close_out;
  end
endmodule
